/* File: core/gpdc_pkg.sv */
package gpdc_pkg;

    // command word codes, one bit at a time
    localparam logic [15:0] CMD_IDLE       = 16'h0000;
    localparam logic [15:0] CMD_PARAM_TAKE = 16'h0001;
    localparam logic [15:0] CMD_CLEAR_DIR  = 16'h0004;
    localparam logic [15:0] CMD_MOVE_OUTER = 16'h0100;
    localparam logic [15:0] CMD_MOVE_INNER = 16'h0200;
    localparam logic [15:0] CMD_FAULT_ACK  = 16'h8000;

    // travel mode codes
    localparam logic [7:0] MODE_OUTSIDE      = 8'h3c;
    localparam logic [7:0] MODE_OUTSIDE_HOLD = 8'h3f;
    localparam logic [7:0] MODE_INSIDE       = 8'h46;
    localparam logic [7:0] MODE_INSIDE_HOLD  = 8'h49;
    localparam logic [7:0] MODE_UNIVERSAL    = 8'h64;
    localparam logic [7:0] MODE_UNIV_HOLD    = 8'h67;

    // state flags word bit positions
    localparam int BIT_BOOT    = 6;
    localparam int BIT_OUTER   = 8;
    localparam int BIT_WINDOW  = 9;
    localparam int BIT_INNER   = 10;
    localparam int BIT_NOPOS   = 11;
    localparam int BIT_ACK     = 12;
    localparam int BIT_DIR_OUT = 13;
    localparam int BIT_DIR_IN  = 14;
    localparam int BIT_FAULT   = 15;

    // positions in hundredths of a millimetre
    localparam logic [15:0] OUTER_JAW_POS = 16'h0000;
    localparam logic [15:0] INNER_JAW_POS = 16'h07d0;
    localparam logic [15:0] EXPECT_MAX    = 16'h07d0;

    localparam logic [7:0] RECIPE_MAX = 8'h20;
    localparam logic [7:0] FORCE_MIN  = 8'h01;
    localparam logic [7:0] FORCE_MAX  = 8'h04;

    // post-grip current feed time
    localparam int HOLD_TIME_MS = 500;
    localparam int CLK_FREQ_KHZ = 50000;
    localparam int HOLD_CYCLES  = HOLD_TIME_MS * CLK_FREQ_KHZ;

    // code reported for a rejected parameter set
    localparam logic [15:0] DIAG_BAD_PARAM = 16'h0001;

    // window index into the position comparators
    localparam int WIN_OUTER  = 0;
    localparam int WIN_EXPECT = 1;
    localparam int WIN_INNER  = 2;
    localparam int WIN_COUNT  = 3;

    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  recipe;
        logic [7:0]  tol;
        logic [7:0]  grip_force;
        logic [15:0] expect_pos;
    } gpdc_params_t;

    localparam gpdc_params_t PARAMS_RST = '{
        mode:       MODE_UNIVERSAL,
        recipe:     8'h00,
        tol:        8'h00,
        grip_force: FORCE_MIN,
        expect_pos: 16'h0000
    };

    typedef enum logic [1:0] {H_IDLE, H_LOAD, H_ACK} gpdc_hs_t;
    typedef enum logic [1:0] {M_IDLE, M_MOVE, M_HOLD, M_GRIPPED}
        gpdc_motion_t;

endpackage

/* File: core/gpdc_pos_window.sv */
`timescale 1ns/10ps
module gpdc_pos_window (
    input  wire logic [15:0] pos,
    input  wire logic [15:0] centre,
    input  wire logic [7:0]  tol,
    output logic             hit
);
    // 17-bit sums so the window never wraps below zero or above the top
    logic [16:0] pos_ext;
    logic [16:0] ctr_ext;
    logic [16:0] tol_ext;

    assign pos_ext = {1'b0, pos};
    assign ctr_ext = {1'b0, centre};
    assign tol_ext = {9'h000, tol};
    assign hit     = (pos_ext + tol_ext >= ctr_ext)
                   && (pos_ext <= ctr_ext + tol_ext);
endmodule

/* File: core/gpdc_hold_timer.sv */
`timescale 1ns/10ps
module gpdc_hold_timer #(
    parameter int CYCLES = 25000000
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic start,
    input  wire logic abort,
    output logic      active,
    output logic      done
);
    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_q;
    logic          active_q;
    logic          done_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_q    <= '0;
            active_q <= 1'b0;
            done_q   <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (abort) begin
                active_q <= 1'b0;
            end else if (start) begin
                cnt_q    <= CW'(CYCLES - 1);
                active_q <= 1'b1;
            end else if (active_q) begin
                if (cnt_q == '0) begin
                    active_q <= 1'b0;
                    done_q   <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end

    assign active = active_q;
    assign done   = done_q;

    timer_starts_a: assert property (@(posedge clk) disable iff (!resetn)
        start && !abort |=> active)
        else $error("hold timer did not start");

    done_after_run_a: assert property (@(posedge clk) disable iff (!resetn)
        done |-> $past(active) && !active)
        else $error("hold done without a running timer");
endmodule

/* File: core/gpdc_process_data.sv */
`timescale 1ns/10ps
// Functional notes
// - mode 63: outside gripping plus hold feed after inward grip.
// - mode 73: inside gripping plus hold feed after outward grip.
// - mode 103: universal, hold feed after grip in either direction.
// - mode 60: inward at force speed, outward at high speed.
// - mode 70: outward at force speed, inward at high speed.
// - mode 100: grip both ways, same speed both ways.
// - travel mode is 8 bits, valid codes 60, 63, 70, 73, 100, 103.
// - reduced variant accepts only modes 60, 70, 100.
// - lost workpiece: keep travelling to end, report a message.
// - recipe 0 uses cyclic values, 1 to 32 loads stored recipe.
// - tolerance in 0.01 mm, symmetric around expected position.
// - force level 1 to 4 sets gripping speed and current.
// - expected position up to 2000 centres the grip window.
// - bit 6 set once boot completes.
// - bits 8, 9, 10: outer, expected window, inner position.
// - bit 11 when at none of the known positions.
// - bit 12 once parameter set adopted after command 1.
// - bit 13 when last motion went toward outer position.
// - bit 14 when last motion went toward inner position.
// - bit 15 while a fault is active, code in diagnosis word.
// - command zero ends handshake, device drops bit 12.
// - command 0x8000 clears resettable faults and bit 15.
module gpdc_process_data #(
    parameter bit REDUCED_VARIANT = 1'b0,
    parameter int HOLD_CYCLES     = gpdc_pkg::HOLD_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic [15:0]            command_word,
    input  wire logic [7:0]             travel_mode,
    input  wire logic [7:0]             recipe_number,
    input  wire logic [7:0]             tolerance_window,
    input  wire logic [7:0]             force_level,
    input  wire logic [15:0]            expected_position,
    input  wire gpdc_pkg::gpdc_params_t recipe_params,
    input  wire logic                   recipe_loaded,
    input  wire logic [15:0]            measured_jaw_pos,
    input  wire logic                   boot_complete,
    input  wire logic                   grip_contact,
    input  wire logic                   fault_event,
    input  wire logic [15:0]            fault_code,
    input  wire logic                   fault_resettable,
    output logic [15:0]                 state_flags_word,
    output logic [15:0]                 diagnosis_word,
    output logic                        recipe_load_req,
    output logic [7:0]                  recipe_load_index,
    output logic                        motor_run,
    output logic                        motor_toward_inner,
    output logic                        motor_high_speed,
    output logic [7:0]                  motor_force_level,
    output logic                        hold_feed_active,
    output logic                        workpiece_lost_msg
);
    gpdc_pkg::gpdc_params_t act_q;
    gpdc_pkg::gpdc_hs_t     hs_q;
    gpdc_pkg::gpdc_motion_t m_q;
    gpdc_pkg::gpdc_motion_t m_d;

    logic [15:0] cmd_prev_q;
    logic        grip_meta_q;
    logic        grip_s_q;
    logic        boot_q;
    logic        fault_q;
    logic        fault_rst_ok_q;
    logic [15:0] diag_q;
    logic        dir_inner_q;
    logic        flag_out_q;
    logic        flag_in_q;
    logic        lost_q;
    logic        load_req_q;
    logic [7:0]  load_idx_q;
    logic [15:0] status_q;
    logic        run_q;
    logic        high_q;
    localparam int WIN_N = gpdc_pkg::WIN_COUNT;

    logic [WIN_N-1:0] win;

    logic        cmd_new;
    logic        take_req;
    logic        cyclic_ok;
    logic        param_bad;
    logic        start_outer;
    logic        start_inner;
    logic        at_target;
    logic        hold_applies;
    logic        hold_start;
    logic        hold_abort;
    logic        hold_act;
    logic        hold_done;
    logic        fault_clear;
    logic        dir_nx;
    logic [15:0] centres [WIN_N];

    function automatic logic mode_ok(input logic [7:0] m);
        unique case (m)
            gpdc_pkg::MODE_OUTSIDE,
            gpdc_pkg::MODE_INSIDE,
            gpdc_pkg::MODE_UNIVERSAL:    mode_ok = 1'b1;
            gpdc_pkg::MODE_OUTSIDE_HOLD,
            gpdc_pkg::MODE_INSIDE_HOLD,
            gpdc_pkg::MODE_UNIV_HOLD:    mode_ok = !REDUCED_VARIANT;
            default:                     mode_ok = 1'b0;
        endcase
    endfunction

    // move, clear and fault commands act once, on the cycle the word changes; command 1 acts each cycle it is held in H_IDLE
    assign cmd_new     = command_word != cmd_prev_q;
    assign take_req    = hs_q == gpdc_pkg::H_IDLE
                       && command_word == gpdc_pkg::CMD_PARAM_TAKE;
    assign cyclic_ok   = mode_ok(travel_mode)
                       && force_level >= gpdc_pkg::FORCE_MIN
                       && force_level <= gpdc_pkg::FORCE_MAX
                       && expected_position <= gpdc_pkg::EXPECT_MAX;
    assign param_bad   = take_req && (recipe_number > gpdc_pkg::RECIPE_MAX
                       || (recipe_number == 8'h00 && !cyclic_ok));
    assign start_outer = cmd_new && !fault_q
                       && command_word == gpdc_pkg::CMD_MOVE_OUTER;
    assign start_inner = cmd_new && !fault_q
                       && command_word == gpdc_pkg::CMD_MOVE_INNER;
    assign fault_clear = cmd_new && fault_rst_ok_q
                       && command_word == gpdc_pkg::CMD_FAULT_ACK;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cmd_prev_q  <= gpdc_pkg::CMD_IDLE;
            grip_meta_q <= 1'b0;
            grip_s_q    <= 1'b0;
            boot_q      <= 1'b0;
        end else begin
            cmd_prev_q  <= command_word;
            grip_meta_q <= grip_contact;
            grip_s_q    <= grip_meta_q;
            if (boot_complete) begin
                boot_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            hs_q       <= gpdc_pkg::H_IDLE;
            act_q      <= gpdc_pkg::PARAMS_RST;
            load_req_q <= 1'b0;
            load_idx_q <= 8'h00;
        end else begin
            load_req_q <= 1'b0;
            unique case (hs_q)
                gpdc_pkg::H_IDLE: begin
                    if (take_req && !param_bad) begin
                        if (recipe_number == 8'h00) begin
                            act_q <= '{mode: travel_mode,
                                       recipe: recipe_number,
                                       tol: tolerance_window,
                                       grip_force: force_level,
                                       expect_pos: expected_position};
                            hs_q  <= gpdc_pkg::H_ACK;
                        end else begin
                            load_req_q <= 1'b1;
                            load_idx_q <= recipe_number;
                            hs_q       <= gpdc_pkg::H_LOAD;
                        end
                    end
                end
                gpdc_pkg::H_LOAD: begin
                    if (recipe_loaded) begin
                        act_q <= recipe_params;
                        hs_q  <= gpdc_pkg::H_ACK;
                    end
                end
                gpdc_pkg::H_ACK: begin
                    if (command_word == gpdc_pkg::CMD_IDLE) begin
                        hs_q <= gpdc_pkg::H_IDLE;
                    end
                end
                default: hs_q <= gpdc_pkg::H_IDLE;
            endcase
        end
    end

    // fault latch, a new fault wins over the acknowledge
    always_ff @(posedge clk) begin
        if (!resetn) begin
            fault_q        <= 1'b0;
            fault_rst_ok_q <= 1'b0;
            diag_q         <= 16'h0000;
        end else if (fault_event || param_bad) begin
            fault_q        <= 1'b1;
            fault_rst_ok_q <= param_bad || fault_resettable;
            diag_q         <= fault_event ? fault_code
                                          : gpdc_pkg::DIAG_BAD_PARAM;
        end else if (fault_clear) begin
            fault_q        <= 1'b0;
            fault_rst_ok_q <= 1'b0;
            diag_q         <= 16'h0000;
        end
    end

    assign centres[gpdc_pkg::WIN_OUTER]  = gpdc_pkg::OUTER_JAW_POS;
    assign centres[gpdc_pkg::WIN_EXPECT] = act_q.expect_pos;
    assign centres[gpdc_pkg::WIN_INNER]  = gpdc_pkg::INNER_JAW_POS;

    for (genvar i = 0; i < WIN_N; i++) begin : g_win
        gpdc_pos_window u_win (
            .pos    (measured_jaw_pos),
            .centre (centres[i]),
            .tol    (act_q.tol),
            .hit    (win[i])
        );
    end

    assign at_target = dir_inner_q ? win[gpdc_pkg::WIN_INNER]
                                   : win[gpdc_pkg::WIN_OUTER];

    // direction taken this cycle, so speed never lags a new move
    assign dir_nx = start_inner || (dir_inner_q && !start_outer);

    // hold feed, never on reduced variant
    assign hold_applies = !REDUCED_VARIANT && (
        (act_q.mode == gpdc_pkg::MODE_OUTSIDE_HOLD && dir_inner_q)
        || (act_q.mode == gpdc_pkg::MODE_INSIDE_HOLD && !dir_inner_q)
        || act_q.mode == gpdc_pkg::MODE_UNIV_HOLD);

    always_comb begin
        m_d = m_q;
        unique case (m_q)
            gpdc_pkg::M_IDLE, gpdc_pkg::M_GRIPPED: begin
                if (start_outer || start_inner) begin
                    m_d = gpdc_pkg::M_MOVE;
                end else if (m_q == gpdc_pkg::M_GRIPPED && !grip_s_q) begin
                    m_d = gpdc_pkg::M_MOVE;
                end
            end
            gpdc_pkg::M_MOVE: begin
                if (fault_q || at_target) begin
                    m_d = gpdc_pkg::M_IDLE;
                end else if (grip_s_q) begin
                    m_d = hold_applies ? gpdc_pkg::M_HOLD
                                       : gpdc_pkg::M_GRIPPED;
                end
            end
            gpdc_pkg::M_HOLD: begin
                if (fault_q) begin
                    m_d = gpdc_pkg::M_IDLE;
                end else if (!grip_s_q) begin
                    m_d = gpdc_pkg::M_MOVE;
                end else if (hold_done) begin
                    m_d = gpdc_pkg::M_GRIPPED;
                end
            end
            default: m_d = gpdc_pkg::M_IDLE;
        endcase
    end

    assign hold_start = m_q == gpdc_pkg::M_MOVE && m_d == gpdc_pkg::M_HOLD;
    assign hold_abort = m_q == gpdc_pkg::M_HOLD && m_d != gpdc_pkg::M_HOLD
                      && !hold_done;

    gpdc_hold_timer #(
        .CYCLES (HOLD_CYCLES)
    ) u_hold (
        .clk    (clk),
        .resetn (resetn),
        .start  (hold_start),
        .abort  (hold_abort),
        .active (hold_act),
        .done   (hold_done)
    );

    always_ff @(posedge clk) begin
        if (!resetn) begin
            m_q         <= gpdc_pkg::M_IDLE;
            dir_inner_q <= 1'b0;
            lost_q      <= 1'b0;
            run_q       <= 1'b0;
            high_q      <= 1'b0;
        end else begin
            m_q   <= m_d;
            run_q <= m_d == gpdc_pkg::M_MOVE || m_d == gpdc_pkg::M_HOLD;
            if (start_inner) begin
                dir_inner_q <= 1'b1;
            end else if (start_outer) begin
                dir_inner_q <= 1'b0;
            end
            // loss reported, travel continues to the end
            if (start_outer || start_inner) begin
                lost_q <= 1'b0;
            end else if ((m_q == gpdc_pkg::M_GRIPPED
                          || m_q == gpdc_pkg::M_HOLD) && !grip_s_q) begin
                lost_q <= 1'b1;
            end
            // speed choice; universal uses force speed both ways
            unique case (act_q.mode)
                gpdc_pkg::MODE_OUTSIDE,
                gpdc_pkg::MODE_OUTSIDE_HOLD: high_q <= !dir_nx;
                gpdc_pkg::MODE_INSIDE,
                gpdc_pkg::MODE_INSIDE_HOLD:  high_q <= dir_nx;
                default:                     high_q <= 1'b0;
            endcase
        end
    end

    // direction flags, cleared on request for a repeat move
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flag_out_q <= 1'b0;
            flag_in_q  <= 1'b0;
        end else if (start_outer || start_inner) begin
            flag_out_q <= start_outer;
            flag_in_q  <= start_inner;
        end else if (cmd_new && command_word == gpdc_pkg::CMD_CLEAR_DIR) begin
            flag_out_q <= 1'b0;
            flag_in_q  <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            status_q <= 16'h0000;
        end else begin
            status_q <= 16'h0000;
            status_q[gpdc_pkg::BIT_BOOT]    <= boot_q;
            status_q[gpdc_pkg::BIT_OUTER]   <= win[gpdc_pkg::WIN_OUTER];
            status_q[gpdc_pkg::BIT_WINDOW]  <= !win[gpdc_pkg::WIN_OUTER]
                                             && win[gpdc_pkg::WIN_EXPECT];
            status_q[gpdc_pkg::BIT_INNER]   <= !win[gpdc_pkg::WIN_OUTER]
                                             && !win[gpdc_pkg::WIN_EXPECT]
                                             && win[gpdc_pkg::WIN_INNER];
            status_q[gpdc_pkg::BIT_NOPOS]   <= win == '0;
            status_q[gpdc_pkg::BIT_ACK]     <= hs_q == gpdc_pkg::H_ACK;
            status_q[gpdc_pkg::BIT_DIR_OUT] <= flag_out_q;
            status_q[gpdc_pkg::BIT_DIR_IN]  <= flag_in_q;
            status_q[gpdc_pkg::BIT_FAULT]   <= fault_q;
        end
    end

    assign state_flags_word   = status_q;
    assign diagnosis_word     = diag_q;
    assign recipe_load_req    = load_req_q;
    assign recipe_load_index  = load_idx_q;
    assign motor_run          = run_q;
    assign motor_toward_inner = dir_inner_q;
    assign motor_high_speed   = high_q;
    assign motor_force_level  = act_q.grip_force;
    assign hold_feed_active   = hold_act;
    assign workpiece_lost_msg = lost_q;

    sequence s_grip_lost;
        m_q == gpdc_pkg::M_GRIPPED && !grip_s_q && !fault_q
            && !start_outer && !start_inner;
    endsequence
    sequence s_resume_report;
        m_q == gpdc_pkg::M_MOVE && lost_q && run_q;
    endsequence

    lost_resume_a: assert property (@(posedge clk) disable iff (!resetn)
        s_grip_lost |=> s_resume_report)
        else $error("workpiece loss did not resume travel");

    ack_drop_a: assert property (@(posedge clk) disable iff (!resetn)
        hs_q == gpdc_pkg::H_ACK && command_word == gpdc_pkg::CMD_IDLE
        |-> ##2 !state_flags_word[gpdc_pkg::BIT_ACK])
        else $error("ack flag stayed after command zero");

    one_pos_bit_a: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) |-> $onehot(state_flags_word[11:8]))
        else $error("position flags not one-hot");

    fault_report_a: assert property (@(posedge clk) disable iff (!resetn)
        fault_event |-> ##1 diag_q == $past(fault_code)
        ##1 state_flags_word[gpdc_pkg::BIT_FAULT])
        else $error("fault not reported");

    fault_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        fault_clear && !fault_event && !param_bad
        |=> !fault_q ##1 !state_flags_word[gpdc_pkg::BIT_FAULT])
        else $error("fault ack did not clear fault");

    dir_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        start_outer |-> ##2 state_flags_word[gpdc_pkg::BIT_DIR_OUT]
        && !state_flags_word[gpdc_pkg::BIT_DIR_IN])
        else $error("outer direction flag wrong");

    hold_entry_a: assert property (@(posedge clk) disable iff (!resetn)
        hold_start |-> hold_applies && !REDUCED_VARIANT
        ##1 m_q == gpdc_pkg::M_HOLD ##1 hold_feed_active)
        else $error("hold feed entered wrongly");

    boot_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        boot_complete |-> ##2 state_flags_word[gpdc_pkg::BIT_BOOT])
        else $error("boot flag not raised");

    adopt_ack_a: assert property (@(posedge clk) disable iff (!resetn)
        take_req && !param_bad && recipe_number == 8'h00
        |-> ##2 state_flags_word[gpdc_pkg::BIT_ACK])
        else $error("parameter adoption not acknowledged");
endmodule

/* File: dv/gpdc_recipe_store.sv */
`timescale 1ns/10ps
module gpdc_recipe_store (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              load_req,
    input  wire logic [7:0]        load_index,
    output gpdc_pkg::gpdc_params_t params,
    output logic                   loaded
);
    logic [2:0] dly_q;
    logic [7:0] idx_q;
    gpdc_pkg::gpdc_params_t set_v;
    // stored set, answered three cycles late
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dly_q <= 3'h0;
        end else begin
            dly_q <= {dly_q[1:0], load_req};
        end
        if (load_req) begin
            idx_q <= load_index;
        end
    end
    assign set_v = '{mode: gpdc_pkg::MODE_UNIVERSAL, recipe: idx_q,
                     tol: 8'h0a, grip_force: 8'h02, expect_pos: 16'h0100};
    // data only meaningful with the strobe, garbage otherwise
    assign params = dly_q[2] ? set_v : ~set_v;
    assign loaded = dly_q[2];
endmodule

/* File: dv/gpdc_process_data_tb.sv */
`timescale 1ns/10ps
module gpdc_process_data_tb;
    logic                   clk, resetn, boot, grip, lreq, ldd, fev, frs;
    logic                   run, inw, fast, hold, lost;
    logic [15:0]            cmd, epos, jpos, flags, diag, fcd;
    logic [7:0]             mode, rec, tol, frc, lidx, mfl;
    gpdc_pkg::gpdc_params_t rp;
    int                     fail_count, comparisons, k, n;
    logic [15:0]            pv [6] = '{0, 1350, 1650, 1651, 2000, 1349};
    logic [3:0]             pe [6] = '{1, 2, 2, 8, 4, 8};
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    gpdc_process_data #(.HOLD_CYCLES(20)) gpdc_process_data_i (
        .clk(clk), .resetn(resetn), .command_word(cmd), .travel_mode(mode),
        .recipe_number(rec), .tolerance_window(tol), .force_level(frc),
        .expected_position(epos), .recipe_params(rp), .recipe_loaded(ldd),
        .measured_jaw_pos(jpos), .boot_complete(boot), .grip_contact(grip),
        .fault_event(fev), .fault_code(fcd), .fault_resettable(frs),
        .state_flags_word(flags), .diagnosis_word(diag),
        .recipe_load_req(lreq), .recipe_load_index(lidx), .motor_run(run),
        .motor_toward_inner(inw), .motor_high_speed(fast),
        .motor_force_level(mfl), .hold_feed_active(hold),
        .workpiece_lost_msg(lost));
    gpdc_recipe_store gpdc_recipe_store_i (.clk(clk), .resetn(resetn),
        .load_req(lreq), .load_index(lidx), .params(rp), .loaded(ldd));
    task automatic summarize();
        $display("mismatches %0d of %0d checks", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // read at the edge: values settled in the cycle before
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic lim(input int c, input int m);
        if (c >= m) begin
            fail_count++;
            $display("[FAIL] %0t wait limit reached", $time);
            summarize();
        end
    endtask
    task automatic wait_bit(input int b, input logic v);
        for (k = 0; k < 300 && flags[b] !== v; k++) @(posedge clk);
        lim(k, 300);
    endtask
    task automatic xfer(input logic [7:0] m, r, f);
        mode <= m; rec <= r; frc <= f; cmd <= 16'h0001;
        wait_bit(12, 1'b1);
        cmd <= 16'h0000;
        wait_bit(12, 1'b0);
    endtask
    initial begin
        {resetn, boot, grip, fev, frs, fcd, cmd, mode, rec, frc} = '0;
        tol = 8'd150; epos = 16'd1500; jpos = 16'd1000;
        fail_count = 0; comparisons = 0;
        cyc(20);
        resetn <= 1'b1; boot <= 1'b1;
        cyc(3);
        chk(flags[6], 1);
        xfer(gpdc_pkg::MODE_UNIV_HOLD, 0, 4);
        for (int i = 0; i < 6; i++) begin
            jpos <= pv[i];
            cyc(3);
            chk(flags[11:8], pe[i]);
        end
        jpos <= 16'd1000; cmd <= gpdc_pkg::CMD_MOVE_INNER;
        cyc(3);
        chk({flags[14:13], run, inw, fast}, 5'b10110);
        grip <= 1'b1;
        for (k = 0; k < 100 && hold !== 1'b1; k++) @(posedge clk);
        lim(k, 100);
        for (n = 0; n < 100 && hold === 1'b1; n++) @(posedge clk);
        lim(n, 100);
        chk(n, 20);
        grip <= 1'b0;
        cyc(5);
        chk({lost, run, inw}, 3'b111);
        jpos <= 16'd2000; cmd <= 16'h0000;
        cyc(3);
        xfer(gpdc_pkg::MODE_OUTSIDE, 0, 2);
        jpos <= 16'd1000; cmd <= gpdc_pkg::CMD_MOVE_OUTER;
        cyc(3);
        chk({flags[14:13], inw, fast, mfl}, 12'h502);
        jpos <= 16'd0; cmd <= 16'h0000;
        cyc(3);
        chk(run, 0);
        frc <= 8'h05; cmd <= 16'h0001;
        cyc(4);
        chk({flags[15:12], diag}, 20'ha0001);
        cmd <= 16'h0000;
        cyc(2);
        frc <= 8'h03; cmd <= gpdc_pkg::CMD_FAULT_ACK;
        cyc(4);
        chk({flags[15], diag}, 17'h0);
        cmd <= 16'h0000;
        cyc(2);
        xfer(gpdc_pkg::MODE_OUTSIDE, 5, 3);
        chk({lidx, mfl}, 16'h0502);
        fev <= 1'b1; fcd <= 16'h0042; frs <= 1'b0;
        cyc(1);
        fev <= 1'b0;
        cyc(3);
        chk({flags[15], diag}, 17'h10042);
        cmd <= gpdc_pkg::CMD_FAULT_ACK;
        cyc(4);
        chk({flags[15], diag}, 17'h10042);
        cmd <= gpdc_pkg::CMD_MOVE_INNER;
        cyc(3);
        chk({flags[14:13], run}, 3'b010);
        resetn <= 1'b0; cmd <= 16'h0000;
        cyc(3);
        resetn <= 1'b1;
        cyc(1);
        chk(flags, 16'h0000);
        chk({diag, mfl}, 24'h000001);
        cyc(2);
        chk(flags, 16'h0140);
        xfer(gpdc_pkg::MODE_INSIDE, 0, 1);
        cmd <= gpdc_pkg::CMD_MOVE_INNER;
        cyc(3);
        chk({run, inw, fast}, 3'b111);
        summarize();
    end
endmodule
